/* logic/umr_channel_mode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "umr_params.svh"

module umr_channel_mode (
   input wire logic mclk,
   input wire logic arst_n,
   input wire umr_pkg::umr_bus_type bus,
   input wire logic ptrReset,
   output logic [7:0] rdData,
   input wire logic oprSet,
   input wire logic oprClear,
   output logic oprBitZero,
   output logic requestToSendOutAN,
   input wire logic txEnabled,
   input wire logic txDrained,
   input wire logic bitTick,
   input wire logic rxCharAvailable,
   input wire logic rxLineIn,
   input wire logic txCoreOut,
   output logic txSerialOutA,
   output logic rxCoreIn,
   input wire logic txCharReq,
   input wire logic clearToSendInA,
   output logic txCharGo,
   output logic [3:0] stopBitLength,
   output umr_pkg::umr_chmode_type chanMode
);
   import umr_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   umr_state_type s_r;
   umr_state_type s_nxt;
   logic hit;
   logic wrTwo;
   umr_chmode_type oldMode;
   umr_chmode_type newMode;
   umr_chmode_type effMode;
   logic autoCond;

   assign hit = (bus.addr == `UMR_OFF_MODE);
   assign wrTwo = bus.wrStrobe && hit && (s_r.ptr == PTR_TWO);
   assign oldMode = umr_chmode_type'(s_r.modeRegTwo[`UMR_CHMODE_HI:`UMR_CHMODE_LO]);
   assign autoCond = s_r.modeRegTwo[`UMR_RTS_CTL_BIT] && !txEnabled && txDrained;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      effMode = CHM_NORMAL;
      s_nxt.rdData = 8'h00;
      // Pointer and register storage.
      if (ptrReset) begin
         s_nxt.ptr = PTR_ONE;
      end else if ((bus.wrStrobe || bus.rdStrobe) && hit && s_r.ptr == PTR_ONE) begin
         s_nxt.ptr = PTR_TWO;
      end
      if (bus.wrStrobe && hit) begin
         if (s_r.ptr == PTR_ONE) begin
            s_nxt.modeRegOne = bus.wrData;
         end else begin
            s_nxt.modeRegTwo = bus.wrData;
         end
      end
      if (bus.rdStrobe && hit) begin
         s_nxt.rdData = (s_r.ptr == PTR_ONE) ? s_r.modeRegOne : s_r.modeRegTwo;
      end
      // Stop-bit window opens when the receiver flags a character, lasts to the next tick.
      s_nxt.rxAvailD = rxCharAvailable;
      if (rxCharAvailable && !s_r.rxAvailD) begin
         s_nxt.stopWin = 1'b1;
      end else if (bitTick) begin
         s_nxt.stopWin = 1'b0;
         s_nxt.echoHold = 1'b0;
      end
      newMode = umr_chmode_type'(s_nxt.modeRegTwo[`UMR_CHMODE_HI:`UMR_CHMODE_LO]);
      // Leaving echo or remote loopback inside the window with the transmitter enabled keeps echo running.
      if (wrTwo && (oldMode == CHM_ECHO || oldMode == CHM_REMOTE_LOOP) &&
          newMode != oldMode && s_r.stopWin && txEnabled) begin
         s_nxt.echoHold = 1'b1;
      end
      // The mode is taken from the value being written so it acts at the same edge.
      effMode = newMode;
      case (effMode)
         CHM_NORMAL: begin
            s_nxt.txOut = txCoreOut;
            s_nxt.rxOut = rxLineIn;
         end
         CHM_ECHO: begin
            s_nxt.txOut = rxLineIn;
            s_nxt.rxOut = rxLineIn;
         end
         CHM_LOCAL_LOOP: begin
            s_nxt.txOut = `UMR_MARK;
            s_nxt.rxOut = txCoreOut;
         end
         CHM_REMOTE_LOOP: begin
            s_nxt.txOut = rxLineIn;
            s_nxt.rxOut = `UMR_MARK;
         end
         default: begin
            s_nxt.txOut = `UMR_MARK;
            s_nxt.rxOut = `UMR_MARK;
         end
      endcase
      // Only the transmitter stays in echo; the receiver follows the new mode at once.
      if (s_nxt.echoHold) begin
         s_nxt.txOut = rxLineIn;
      end
      // Request-to-send: two ticks seen while drained span at least one full bit time.
      if (!autoCond || !s_r.oprBit) begin
         s_nxt.rtsArmed = 1'b0;
      end else if (bitTick) begin
         s_nxt.rtsArmed = !s_r.rtsArmed;
         if (s_r.rtsArmed) begin
            s_nxt.oprBit = 1'b0;
         end
      end
      if (oprClear) begin
         s_nxt.oprBit = 1'b0;
      end
      if (oprSet) begin
         s_nxt.oprBit = 1'b1;
         s_nxt.rtsArmed = 1'b0;
      end
      s_nxt.rtsPinN = !s_nxt.oprBit;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_r <= '{ptr: PTR_ONE, modeRegOne: `UMR_MODE_ONE_RESET,
                  modeRegTwo: `UMR_MODE_TWO_RESET,
                  txOut: `UMR_MARK, rxOut: `UMR_MARK, rtsPinN: 1'b1, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // A start held back by clear-to-send leaves the line at mark; the grant is looked at only
   // at character start, so a later change cannot cut a character short.
   assign txCharGo = txCharReq && (!s_r.modeRegTwo[`UMR_CTS_EN_BIT] || !clearToSendInA);
   assign rdData = s_r.rdData;
   assign oprBitZero = s_r.oprBit;
   assign requestToSendOutAN = s_r.rtsPinN;
   assign txSerialOutA = s_r.txOut;
   assign rxCoreIn = s_r.rxOut;
   assign stopBitLength = s_r.modeRegTwo[`UMR_STOP_HI:`UMR_STOP_LO];
   assign chanMode = umr_chmode_type'(s_r.modeRegTwo[`UMR_CHMODE_HI:`UMR_CHMODE_LO]);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_ptr_advance: assert property (@(posedge mclk) disable iff (!arst_n)
      (bus.rdStrobe && hit && s_r.ptr == PTR_ONE && !ptrReset) |=> s_r.ptr == PTR_TWO)
      else $error("Pointer did not advance after register one access.");

   a_ptr_stays: assert property (@(posedge mclk) disable iff (!arst_n)
      (s_r.ptr == PTR_TWO && !ptrReset) |=> s_r.ptr == PTR_TWO)
      else $error("Pointer moved without a pointer reset.");

   a_ptr_reset: assert property (@(posedge mclk) disable iff (!arst_n)
      ptrReset |=> s_r.ptr == PTR_ONE)
      else $error("Pointer reset did not return to register one.");

   a_mode_normal: assert property (@(posedge mclk) disable iff (!arst_n)
      (newMode == CHM_NORMAL && !s_nxt.echoHold) |=> txSerialOutA == $past(txCoreOut)
      && rxCoreIn == $past(rxLineIn))
      else $error("Normal mode routing wrong.");

   a_echo_route: assert property (@(posedge mclk) disable iff (!arst_n)
      (newMode == CHM_ECHO) |=> txSerialOutA == $past(rxLineIn)
      && rxCoreIn == $past(rxLineIn))
      else $error("Echo mode routing wrong.");

   a_local_loop: assert property (@(posedge mclk) disable iff (!arst_n)
      (newMode == CHM_LOCAL_LOOP && !s_nxt.echoHold) |=> txSerialOutA == `UMR_MARK
      && rxCoreIn == $past(txCoreOut))
      else $error("Local loopback routing wrong.");

   a_mode_at_once: assert property (@(posedge mclk) disable iff (!arst_n)
      (wrTwo && bus.wrData[`UMR_CHMODE_HI:`UMR_CHMODE_LO] == 2'h3 && !s_nxt.echoHold)
      |=> rxCoreIn == `UMR_MARK && txSerialOutA == $past(rxLineIn))
      else $error("Written mode did not act at the next edge.");

   a_echo_hold: assert property (@(posedge mclk) disable iff (!arst_n)
      (wrTwo && (oldMode == CHM_ECHO || oldMode == CHM_REMOTE_LOOP)
       && bus.wrData[`UMR_CHMODE_HI:`UMR_CHMODE_LO] == 2'h0 && s_r.stopWin && txEnabled
       && !bitTick) |=> txSerialOutA == $past(rxLineIn) && rxCoreIn == $past(rxLineIn))
      else $error("Echo not held to end of stop bit.");

   a_rts_clear: assert property (@(posedge mclk) disable iff (!arst_n)
      (s_r.rtsArmed && bitTick && autoCond && !oprSet) |=> !oprBitZero && requestToSendOutAN)
      else $error("Automatic request-to-send negation missing.");

   a_rts_no_ctl: assert property (@(posedge mclk) disable iff (!arst_n)
      (oprBitZero && !s_r.modeRegTwo[`UMR_RTS_CTL_BIT] && !oprClear) |=> oprBitZero)
      else $error("Output bit cleared without control enabled.");

   a_opr_set: assert property (@(posedge mclk) disable iff (!arst_n)
      oprSet |=> oprBitZero && !requestToSendOutAN)
      else $error("Set of output bit lost.");

   a_cts_gate: assert property (@(posedge mclk) disable iff (!arst_n)
      (s_r.modeRegTwo[`UMR_CTS_EN_BIT] && clearToSendInA) |-> !txCharGo)
      else $error("Character started with clear-to-send negated.");

   a_stop_readback: assert property (@(posedge mclk) disable iff (!arst_n)
      (wrTwo && !ptrReset) ##1 (!bus.wrStrobe && !ptrReset) ##1 (bus.rdStrobe && hit)
      |=> rdData[`UMR_STOP_HI:`UMR_STOP_LO] == $past(bus.wrData[`UMR_STOP_HI:`UMR_STOP_LO], 3))
      else $error("Stop-bit length did not read back.");

endmodule
`default_nettype wire

/* logic/umr_params.svh */
`ifndef UMR_PARAMS_SVH
`define UMR_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define UMR_ADDR_W 4
`define UMR_OFF_MODE 4'h0
`define UMR_MODE_TWO_RESET 8'h00
`define UMR_MODE_ONE_RESET 8'h00

// ----------------------------------------
// Mode register two field positions
// ----------------------------------------
`define UMR_CHMODE_HI 7
`define UMR_CHMODE_LO 6
`define UMR_RTS_CTL_BIT 5
`define UMR_CTS_EN_BIT 4
`define UMR_STOP_HI 3
`define UMR_STOP_LO 0

// ----------------------------------------
// Line levels
// ----------------------------------------
`define UMR_MARK 1'h1

`endif

/* logic/umr_pkg.sv */
package umr_pkg;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      CHM_NORMAL,
      CHM_ECHO,
      CHM_LOCAL_LOOP,
      CHM_REMOTE_LOOP
   } umr_chmode_type;

   typedef enum logic {
      PTR_ONE,
      PTR_TWO
   } umr_ptr_type;

   typedef struct packed {
      logic [3:0] addr;
      logic wrStrobe;
      logic rdStrobe;
      logic [7:0] wrData;
   } umr_bus_type;

   typedef struct packed {
      umr_ptr_type ptr;
      logic [7:0] modeRegOne;
      logic [7:0] modeRegTwo;
      logic oprBit;
      logic rtsArmed;
      logic stopWin;
      logic echoHold;
      logic rxAvailD;
      logic txOut;
      logic rxOut;
      logic rtsPinN;
      logic [7:0] rdData;
   } umr_state_type;

endpackage

/* dv/umr_remote_station.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Remote station on the line and modem pins
// ----------------------------------------
// Levels come straight from the bench so each scenario picks what the station sends.
module umr_remote_station (
   input wire logic lineLvl,
   input wire logic ctsLvl,
   input wire logic txLine,
   input wire logic rtsN,
   output logic rxLine,
   output logic clearToSendN,
   output logic lineSeen,
   output logic rtsSeenN
);
   assign rxLine = lineLvl;
   assign clearToSendN = ctsLvl;
   // The station reports what reaches it so the bench checks the far end of each wire.
   assign lineSeen = txLine;
   assign rtsSeenN = rtsN;
endmodule
`default_nettype wire

/* dv/uart_channel_mode_rts_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module uart_channel_mode_rts_control_test;
   import umr_pkg::*;
   logic mclk, arst_n, ptrReset, oprSet, oprClear, txEnabled, txDrained, bitTick;
   logic rxAvail, txCoreOut, txCharReq, lineLvl, ctsLvl, rxLine, ctsN;
   logic oprBitZero, rtsN, txSer, rxCore, txCharGo, lineSeen, rtsSeenN;
   logic [7:0] rdData;
   logic [7:0] q;
   logic [3:0] stopLen;
   umr_chmode_type chanMode;
   umr_bus_type bus;
   int badCount, checksDone;
   umr_channel_mode umr_channel_mode_inst (.mclk(mclk), .arst_n(arst_n), .bus(bus),
      .ptrReset(ptrReset), .rdData(rdData), .oprSet(oprSet), .oprClear(oprClear),
      .oprBitZero(oprBitZero), .requestToSendOutAN(rtsN), .txEnabled(txEnabled),
      .txDrained(txDrained), .bitTick(bitTick), .rxCharAvailable(rxAvail),
      .rxLineIn(rxLine), .txCoreOut(txCoreOut), .txSerialOutA(txSer), .rxCoreIn(rxCore),
      .txCharReq(txCharReq), .clearToSendInA(ctsN), .txCharGo(txCharGo),
      .stopBitLength(stopLen), .chanMode(chanMode));
   umr_remote_station umr_remote_station_inst (.lineLvl(lineLvl), .ctsLvl(ctsLvl),
      .txLine(txSer), .rtsN(rtsN), .rxLine(rxLine), .clearToSendN(ctsN),
      .lineSeen(lineSeen), .rtsSeenN(rtsSeenN));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic endOfTest;
      if (badCount == 0 && checksDone > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checksDone++;
      if (g !== e) begin
         badCount++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   // One access, then an idle cycle so strobes never restart in the same time step.
   task automatic acc(input logic [3:0] a, input logic wr, input logic [7:0] d);
      bus = '{addr: a, wrStrobe: wr, rdStrobe: !wr, wrData: d};
      cyc(1);
      q = rdData;
      bus = '0;
      cyc(1);
   endtask
   task automatic tick;
      bitTick = 1;
      cyc(1);
      bitTick = 0;
      cyc(1);
   endtask
   function automatic logic [1:0] route(input int m, input logic tc, input logic rl);
      case (m)
         0: route = {tc, rl};
         1: route = {rl, rl};
         2: route = {1'b1, tc};
         default: route = {rl, 1'b1};
      endcase
   endfunction
   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      badCount++;
      endOfTest;
   end
   initial begin
      bus = '0;
      {ptrReset, oprSet, oprClear, txEnabled, txDrained, bitTick, rxAvail} = '0;
      {txCoreOut, txCharReq, lineLvl, ctsLvl} = 4'hf;
      arst_n = 0;
      repeat (12) @(posedge mclk);
      #2;
      arst_n = 1;
      chk("mode", 8'h00, 8'(chanMode));
      chk("rts pin", 8'h01, 8'(rtsN));
      acc(4'h0, 1, 8'h3c);
      acc(4'h0, 1, 8'h15);
      acc(4'h0, 0, 8'h00);
      chk("reg two", 8'h15, q);
      acc(4'h0, 0, 8'h00);
      chk("reg two again", 8'h15, q);
      chk("stop len", 8'h05, 8'(stopLen));
      acc(4'h3, 1, 8'hff);
      acc(4'h0, 0, 8'h00);
      chk("other addr", 8'h15, q);
      ptrReset = 1;
      cyc(1);
      ptrReset = 0;
      acc(4'h0, 0, 8'h00);
      chk("reg one", 8'h3c, q);
      chk("cts high", 8'h00, 8'(txCharGo));
      ctsLvl = 0;
      cyc(1);
      chk("cts low", 8'h01, 8'(txCharGo));
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            acc(4'h0, 1, {m[1:0], 6'h00});
            txCoreOut = p[0];
            lineLvl = !p[0];
            cyc(2);
            chk("mode", 8'(m), 8'(chanMode));
            chk("route", 8'(route(m, p[0], !p[0])), 8'({txSer, rxCore}));
         end
      end
      ctsLvl = 1;
      cyc(1);
      chk("cts off", 8'h01, 8'(txCharGo));
      acc(4'h0, 1, 8'h40);
      txEnabled = 1;
      txCoreOut = 0;
      lineLvl = 1;
      rxAvail = 1;
      cyc(1);
      acc(4'h0, 1, 8'h00);
      chk("echo hold", 8'h01, 8'(txSer));
      chk("station line", 8'h01, 8'(lineSeen));
      tick;
      cyc(1);
      chk("echo end", 8'h00, 8'(txSer));
      acc(4'h0, 1, 8'h40);
      acc(4'h0, 1, 8'h00);
      chk("echo exit", 8'h00, 8'(txSer));
      rxAvail = 0;
      acc(4'h0, 1, 8'h20);
      oprSet = 1;
      cyc(1);
      oprSet = 0;
      cyc(2);
      chk("rts set", 8'h00, 8'(rtsN));
      txEnabled = 0;
      txDrained = 1;
      cyc(1);
      tick;
      cyc(1);
      chk("opr early", 8'h01, 8'(oprBitZero));
      tick;
      cyc(2);
      chk("opr auto", 8'h00, 8'(oprBitZero));
      chk("rts auto", 8'h01, 8'(rtsN));
      chk("station rts", 8'h01, 8'(rtsSeenN));
      acc(4'h0, 1, 8'h00);
      oprSet = 1;
      cyc(1);
      oprSet = 0;
      tick;
      tick;
      tick;
      chk("opr kept", 8'h01, 8'(oprBitZero));
      oprClear = 1;
      cyc(1);
      oprClear = 0;
      cyc(2);
      chk("rts clear", 8'h01, 8'(rtsN));
      // A second reset mid-run must bring back idle lines and the pointer at register one.
      arst_n = 0;
      cyc(2);
      arst_n = 1;
      chk("reset line", 8'h03, 8'({txSer, rxCore}));
      chk("reset mode", 8'h00, 8'(chanMode));
      acc(4'h0, 0, 8'h00);
      chk("reset reg one", 8'h00, q);
      chk("rd idle", 8'h00, rdData);
      endOfTest;
   end
endmodule
`default_nettype wire
